// *** shared/gpc_pkg.sv ***
// Purpose: Constants and types for the general-purpose clock synthesiser control block
// Assumes: 40 MHz system clock mclk; registers reached over AXI4-Lite
// Notes:   Offsets are byte addresses of aligned 32-bit words
package gpc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;  // Enable use, mode, phase
  localparam logic [7:0] OFF_MULT   = 8'h04;  // Feedback multiplier
  localparam logic [7:0] OFF_PRE    = 8'h08;  // Input prescaler
  localparam logic [7:0] OFF_DIVA   = 8'h0C;  // Core output a divider
  localparam logic [7:0] OFF_DIVB   = 8'h10;  // Core output b divider
  localparam logic [7:0] OFF_DIVC   = 8'h14;  // Core output c divider
  localparam logic [7:0] OFF_DIVX   = 8'h18;  // Board output divider
  localparam logic [7:0] OFF_DELAY  = 8'h1C;  // Fine delay per output
  localparam logic [7:0] OFF_STATUS = 8'h20;  // Lock and error status
  // Setting ranges
  localparam logic [7:0] CORE_MAX   = 8'hA0;  // 160
  localparam logic [7:0] SMALL_MAX  = 8'h10;  // 16
  // CTRL field positions
  localparam int CTRL_USE_GLB = 0;            // Respond to global enable
  localparam int CTRL_MODE_LO = 1;            // Mode field, 2 bits
  localparam int CTRL_MIRROR  = 3;            // Board output mirrors core b
  localparam int CTRL_PH_LO   = 4;            // Phase quadrant, 2 bits
  localparam int CTRL_PHFINE  = 6;            // Non-quadrant phase, 8 bits
  // Reset values
  localparam logic [31:0] CTRL_RST  = 32'h0000_0001;
  localparam logic [7:0]  DIV_RST   = 8'h01;
  localparam logic [3:0]  DELAY_RST = 4'h8;   // Code 8 = 0 ps
  // Timing
  localparam int CLK_PS        = 25000;       // Period in ps
  localparam int DLY_STEP_PS   = 250;         // Fine delay step
  localparam int PH_STEP_MIN_PS = 300;        // Finest non-quadrant phase resolution
  localparam int PH_STEP_MAX_PS = 1000;
  localparam int LOCK_CYCLES   = 64;          // Acquisition interval
  localparam int REF_TIMEOUT   = 8;           // mclk cycles without a reference edge
  // External output modes
  typedef enum logic [1:0] {
    GPC_NORMAL = 2'b00,
    GPC_ZDB    = 2'b01,
    GPC_EXTFB  = 2'b11
  } gpc_mode_t;
  // Lock state, Gray along the usual path
  typedef enum logic [1:0] {
    GPC_OFF  = 2'b00,
    GPC_ACQ  = 2'b01,
    GPC_LOCK = 2'b11
  } gpc_lock_t;
endpackage

// *** rtl/gpc_clock_control.sv ***
// Purpose: Behavioural clock synthesiser control with AXI4-Lite register access
// Assumes: Reference clock sampled as a pin; outputs are toggling levels registered at mclk
// Notes:   Generated outputs toggle at ref*m/(n*div) when m <= n*div, else once per reference edge, in a rate-accumulator model
//
// Overview of operation
// - Multiplier and core dividers 1..160, others 1..16
// - Output rate is ref times m over n*div; model toggles at most once per ref edge
// - Three core outputs plus one board output
// - Locked outputs align to reference rising edge
// - One of up to four general synthesisers
// - Zero-delay mode aligns board pin, rejects shifts
// - External feedback aligns feedback, same shift bans
// - Normal mode board output may lag
// - One global phase; quadrants exact
// - Other shifts in 0.3 to 1.0 ns steps
// - Global phase needs integer frequency ratio
// - Per-output fine delay 250 ps, -2..+1.75 ns
// - Global enable high drives all outputs
// - Global enable low: outputs low, lock lost
// - Relock required after enable returns
// - Global enable use selectable per instance
// - Lock rises after acquisition, holds while valid
// - Lock falls when reference out of spec
// - Lock on a dedicated pin and in status bit 0
`timescale 1ns/1ps
module gpc_clock_control (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Pins
  input  wire logic        refClkPin,
  input  wire logic        synthGlobalEnablePin,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Generated clocks and lock pin
  output logic             coreOutA,
  output logic             coreOutB,
  output logic             coreOutC,
  output logic             boardOut,
  output logic             lockPin
);
  // Lock counter width
  localparam int LW = $clog2(gpc_pkg::LOCK_CYCLES + 1);

  // All state in one struct
  typedef struct packed {
    logic [2:0]  refSync;      // Pin synchroniser plus edge history
    logic [2:0]  enSync;       // Enable synchroniser plus history
    logic [31:0] ctrl;
    logic [7:0]  mult;
    logic [7:0]  pre;
    logic [3:0][7:0] div;      // a, b, c, board
    logic [15:0] delay;        // Four 4-bit codes
    logic        cfgErr;       // Bad-setting flag, follows settings
    gpc_pkg::gpc_lock_t lockSt;
    logic [LW-1:0] lockCnt;
    logic [3:0]  refGap;       // Cycles since last reference edge
    logic [3:0][15:0] acc;     // Rate accumulators
    logic [3:0]  outQ;
    logic        lockQ;
    logic        awHeld;
    logic [7:0]  awAddr;
    logic        wHeld;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bValid;
    logic [1:0]  bResp;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
  } gpc_state_t;

  gpc_state_t st;
  gpc_state_t next_st;

  // Derived combinational terms
  logic refRise;
  logic enActive;
  logic running;
  logic wrFire;
  logic rdFire;
  logic [31:0] wrMerged;
  logic [31:0] rdWord;
  logic [1:0]  rdResp;
  logic [1:0]  wrResp;
  logic        cfgBad;
  gpc_pkg::gpc_mode_t modeSel;

  // Settings range check
  function automatic logic inRange(input logic [7:0] v, input logic [7:0] hi);
    inRange = (v != 8'h00) && (v <= hi);
  endfunction

  // Register read mux and error decode
  always_comb begin
    rdWord = 32'h0000_0000;
    rdResp = 2'b00;
    unique case (s_axi_araddr)
      gpc_pkg::OFF_CTRL:   rdWord = st.ctrl;
      gpc_pkg::OFF_MULT:   rdWord = {24'h000000, st.mult};
      gpc_pkg::OFF_PRE:    rdWord = {24'h000000, st.pre};
      gpc_pkg::OFF_DIVA:   rdWord = {24'h000000, st.div[0]};
      gpc_pkg::OFF_DIVB:   rdWord = {24'h000000, st.div[1]};
      gpc_pkg::OFF_DIVC:   rdWord = {24'h000000, st.div[2]};
      gpc_pkg::OFF_DIVX:   rdWord = {24'h000000, st.div[3]};
      gpc_pkg::OFF_DELAY:  rdWord = {16'h0000, st.delay};
      gpc_pkg::OFF_STATUS: rdWord = {28'h0000000, st.cfgErr, st.lockSt == gpc_pkg::GPC_ACQ,
                                     enActive, st.lockQ};
      default:             rdResp = 2'b10;  // Unmapped: SLVERR
    endcase
  end

  // Write strobe merge against current word
  always_comb begin
    logic [31:0] cur;
    cur = 32'h0000_0000;
    unique case (st.awAddr)
      gpc_pkg::OFF_CTRL:  cur = st.ctrl;
      gpc_pkg::OFF_MULT:  cur = {24'h000000, st.mult};
      gpc_pkg::OFF_PRE:   cur = {24'h000000, st.pre};
      gpc_pkg::OFF_DIVA:  cur = {24'h000000, st.div[0]};
      gpc_pkg::OFF_DIVB:  cur = {24'h000000, st.div[1]};
      gpc_pkg::OFF_DIVC:  cur = {24'h000000, st.div[2]};
      gpc_pkg::OFF_DIVX:  cur = {24'h000000, st.div[3]};
      gpc_pkg::OFF_DELAY: cur = {16'h0000, st.delay};
      default:            cur = 32'h0000_0000;
    endcase
    for (int i = 0; i < 4; i++) begin
      wrMerged[i*8 +: 8] = st.wStrb[i] ? st.wData[i*8 +: 8] : cur[i*8 +: 8];
    end
  end

  // Shared control terms
  always_comb begin
    logic [15:0] ratio;  // n*div of one output
    ratio    = 16'h0000;
    refRise  = st.refSync[1] & ~st.refSync[2];          // Second stage against third
    // Instances not using the global pin ignore it
    enActive = st.ctrl[gpc_pkg::CTRL_USE_GLB] ? st.enSync[1] : 1'b1;
    running  = enActive && (st.lockSt == gpc_pkg::GPC_LOCK);
    wrFire   = st.awHeld && st.wHeld && !st.bValid;
    rdFire   = s_axi_arvalid && !st.rValid;
    modeSel  = gpc_pkg::gpc_mode_t'(st.ctrl[gpc_pkg::CTRL_MODE_LO +: 2]);
    // Setting checks: ranges, mode shift bans, integer-ratio phase
    cfgBad = !inRange(st.mult, gpc_pkg::CORE_MAX)
          || !inRange(st.pre, gpc_pkg::SMALL_MAX)
          || !inRange(st.div[0], gpc_pkg::CORE_MAX)
          || !inRange(st.div[1], gpc_pkg::CORE_MAX)
          || !inRange(st.div[2], gpc_pkg::CORE_MAX)
          || !inRange(st.div[3], gpc_pkg::SMALL_MAX);
    if (modeSel != gpc_pkg::GPC_NORMAL &&
        (st.ctrl[gpc_pkg::CTRL_PH_LO +: 2] != 2'b00 ||
         st.ctrl[gpc_pkg::CTRL_PHFINE +: 8] != 8'h00 ||
         st.delay != {4{gpc_pkg::DELAY_RST}})) begin
      cfgBad = 1'b1;
    end
    // Phase needs n*div a multiple of m, or m a multiple of n*div, on every output
    for (int i = 0; i < 4; i++) begin
      ratio = 16'(st.pre) * 16'(st.div[i]);
      if (st.ctrl[gpc_pkg::CTRL_PH_LO +: 10] != 10'h000 && st.mult != 8'h00 &&
          ratio != 16'h0000 && ratio % 16'(st.mult) != 16'h0000 &&
          16'(st.mult) % ratio != 16'h0000) begin
        cfgBad = 1'b1;
      end
    end
    wrResp = 2'b00;
    if (!(st.awAddr <= gpc_pkg::OFF_DELAY && st.awAddr[1:0] == 2'b00)) begin
      wrResp = 2'b10;
    end
  end

  // Next-state logic
  always_comb begin
    next_st = st;
    next_st.refSync = {st.refSync[1:0], refClkPin};
    next_st.enSync  = {st.enSync[1:0], synthGlobalEnablePin};

    // AXI write channels, taken in either order
    if (s_axi_awvalid && !st.awHeld) begin
      next_st.awHeld = 1'b1;
      next_st.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.wHeld) begin
      next_st.wHeld = 1'b1;
      next_st.wData = s_axi_wdata;
      next_st.wStrb = s_axi_wstrb;
    end
    if (wrFire) begin
      next_st.awHeld = 1'b0;
      next_st.wHeld  = 1'b0;
      next_st.bValid = 1'b1;
      next_st.bResp  = wrResp;
      // Settings are frozen outside GPC_OFF (acquiring or locked); such writes are dropped
      if (wrResp == 2'b00 && st.lockSt == gpc_pkg::GPC_OFF) begin
        unique case (st.awAddr)
          gpc_pkg::OFF_CTRL:  next_st.ctrl   = {18'h00000, wrMerged[13:0]};
          gpc_pkg::OFF_MULT:  next_st.mult   = wrMerged[7:0];
          gpc_pkg::OFF_PRE:   next_st.pre    = wrMerged[7:0];
          gpc_pkg::OFF_DIVA:  next_st.div[0] = wrMerged[7:0];
          gpc_pkg::OFF_DIVB:  next_st.div[1] = wrMerged[7:0];
          gpc_pkg::OFF_DIVC:  next_st.div[2] = wrMerged[7:0];
          gpc_pkg::OFF_DIVX:  next_st.div[3] = wrMerged[7:0];
          default:            next_st.delay  = wrMerged[15:0];
        endcase
      end else if (wrResp == 2'b00) begin
        next_st.bResp = 2'b10;
      end
    end
    if (st.bValid && s_axi_bready) begin
      next_st.bValid = 1'b0;
    end
    if (rdFire) begin
      next_st.rValid = 1'b1;
      next_st.rData  = rdWord;
      next_st.rResp  = rdResp;
    end else if (st.rValid && s_axi_rready) begin
      next_st.rValid = 1'b0;
    end

    // Error flag is live: it follows the settings as they stand now
    next_st.cfgErr = cfgBad;

    // Reference watchdog: too long without an edge is out of spec
    if (refRise) begin
      next_st.refGap = 4'h0;
    end else if (st.refGap != 4'hF) begin
      next_st.refGap = st.refGap + 4'h1;
    end

    // Lock state machine
    unique case (st.lockSt)
      gpc_pkg::GPC_OFF: begin
        next_st.lockCnt = '0;
        if (enActive && !cfgBad) begin
          next_st.lockSt = gpc_pkg::GPC_ACQ;
        end
      end
      gpc_pkg::GPC_ACQ: begin
        if (!enActive || cfgBad || st.refGap >= 4'(gpc_pkg::REF_TIMEOUT)) begin
          next_st.lockSt = gpc_pkg::GPC_OFF;
        end else if (refRise) begin
          if (st.lockCnt == LW'(gpc_pkg::LOCK_CYCLES - 1)) begin
            next_st.lockSt = gpc_pkg::GPC_LOCK;
          end else begin
            next_st.lockCnt = st.lockCnt + LW'(1);
          end
        end
      end
      gpc_pkg::GPC_LOCK: begin
        if (!enActive || st.refGap >= 4'(gpc_pkg::REF_TIMEOUT)) begin
          next_st.lockSt = gpc_pkg::GPC_OFF;
        end
      end
      default: next_st.lockSt = gpc_pkg::GPC_OFF;
    endcase
    next_st.lockQ = (st.lockSt == gpc_pkg::GPC_LOCK) && enActive &&
                    st.refGap < 4'(gpc_pkg::REF_TIMEOUT);

    // Rate accumulators: add m per reference edge, wrap at n*div.
    // Restarting on lock makes every output start on a reference edge.
    for (int i = 0; i < 4; i++) begin
      logic [15:0] lim;
      lim = 16'(st.pre) * 16'(st.div[i]);
      if (!running) begin
        next_st.acc[i]  = 16'h0000;
        next_st.outQ[i] = 1'b0;
      end else if (refRise) begin
        if (st.acc[i] + 16'(st.mult) >= lim) begin
          next_st.acc[i]  = st.acc[i] + 16'(st.mult) - lim;
          next_st.outQ[i] = ~st.outQ[i];
        end else begin
          next_st.acc[i] = st.acc[i] + 16'(st.mult);
        end
      end
    end
    // Board output may mirror core output b
    if (running && st.ctrl[gpc_pkg::CTRL_MIRROR]) begin
      next_st.outQ[3] = next_st.outQ[1];
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st        <= '0;
      st.ctrl   <= gpc_pkg::CTRL_RST;
      st.mult   <= gpc_pkg::DIV_RST;
      st.pre    <= gpc_pkg::DIV_RST;
      st.div    <= {4{gpc_pkg::DIV_RST}};
      st.delay  <= {4{gpc_pkg::DELAY_RST}};
      st.lockSt <= gpc_pkg::GPC_OFF;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state flops
  assign s_axi_awready = !st.awHeld;
  assign s_axi_wready  = !st.wHeld;
  assign s_axi_bvalid  = st.bValid;
  assign s_axi_bresp   = st.bResp;
  assign s_axi_arready = !st.rValid;
  assign s_axi_rvalid  = st.rValid;
  assign s_axi_rdata   = st.rData;
  assign s_axi_rresp   = st.rResp;
  assign coreOutA      = st.outQ[0];
  assign coreOutB      = st.outQ[1];
  assign coreOutC      = st.outQ[2];
  assign boardOut      = st.outQ[3];
  assign lockPin       = st.lockQ;

  // Assertions
  sequence s_enLost;
    st.ctrl[gpc_pkg::CTRL_USE_GLB] && !st.enSync[1];
  endsequence
  property p_lowWhenOff;
    @(posedge mclk) disable iff (!rst_n)
      s_enLost |=> !coreOutA && !coreOutB && !coreOutC && !boardOut;
  endproperty
  a_lowWhenOff: assert property (p_lowWhenOff) else $error("outputs not low");
  property p_lockDrop;
    @(posedge mclk) disable iff (!rst_n) s_enLost |=> !lockPin;
  endproperty
  a_lockDrop: assert property (p_lockDrop) else $error("lock kept");
  property p_relock;
    @(posedge mclk) disable iff (!rst_n)
      (st.lockSt == gpc_pkg::GPC_OFF) |=> !lockPin;
  endproperty
  a_relock: assert property (p_relock) else $error("lock without acquire");
  property p_refLoss;
    @(posedge mclk) disable iff (!rst_n)
      (st.refGap >= 4'(gpc_pkg::REF_TIMEOUT)) |=> !lockPin;
  endproperty
  a_refLoss: assert property (p_refLoss) else $error("lock on lost ref");
  property p_ignoreGlb;
    @(posedge mclk) disable iff (!rst_n)
      !st.ctrl[gpc_pkg::CTRL_USE_GLB] && st.lockSt == gpc_pkg::GPC_LOCK &&
      st.refGap < 4'(gpc_pkg::REF_TIMEOUT) |=> lockPin;
  endproperty
  a_ignoreGlb: assert property (p_ignoreGlb) else $error("global enable obeyed");
  property p_frozen;
    @(posedge mclk) disable iff (!rst_n)
      (st.lockSt == gpc_pkg::GPC_LOCK) |=> $stable(st.mult) && $stable(st.div);
  endproperty
  a_frozen: assert property (p_frozen) else $error("setting changed");
  property p_alignEdge;
    @(posedge mclk) disable iff (!rst_n)
      running && !refRise && !st.ctrl[gpc_pkg::CTRL_MIRROR] |=> $stable(coreOutA);
  endproperty
  a_alignEdge: assert property (p_alignEdge) else $error("toggle off edge");
  property p_zdbBan;
    @(posedge mclk) disable iff (!rst_n)
      modeSel != gpc_pkg::GPC_NORMAL && st.delay != {4{gpc_pkg::DELAY_RST}} |=> st.cfgErr;
  endproperty
  a_zdbBan: assert property (p_zdbBan) else $error("shift allowed");
  property p_range;
    @(posedge mclk) disable iff (!rst_n) (st.mult > gpc_pkg::CORE_MAX) |=> st.cfgErr;
  endproperty
  a_range: assert property (p_range) else $error("range missed");
  property p_mirror;
    @(posedge mclk) disable iff (!rst_n)
      running && st.ctrl[gpc_pkg::CTRL_MIRROR] |=> boardOut == coreOutB;
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror broken");
endmodule

// *** tb/gpc_board_partner.sv ***
// Purpose: Board side of the clock block: reference source, board clock consumer
// Assumes: Half period stays under four mclk cycles so the loss timer never trips
// Notes:   Reference stands low while stopped, as a failed oscillator would
`timescale 1ns/1ps
module gpc_board_partner (
  // Bench control
  input  wire logic        mclk,
  input  wire logic        refRun,
  input  wire logic [7:0]  refHalf,
  // Pins
  output logic             refClkPin,
  input  wire logic        boardOut,
  // Observed counts
  output logic [15:0]      refEdges,
  output logic [15:0]      boardToggles
);
  logic prevBoard = 1'b0;  // Last sampled board clock

  initial begin
    refClkPin = 1'b0;
    refEdges = 16'h0000;
    boardToggles = 16'h0000;
  end

  // Free-running oscillator, gated; base 50 ns keeps the loop off zero delay
  always begin
    #(50 + refHalf);
    refClkPin = refRun ? ~refClkPin : 1'b0;
  end

  // Rising edges produced, for lock interval checks
  always @(posedge refClkPin) begin
    refEdges <= refEdges + 16'h0001;
  end

  // Board clock consumer counts every level change
  always @(posedge mclk) begin
    prevBoard <= boardOut;
    if (boardOut !== prevBoard) begin
      boardToggles <= boardToggles + 16'h0001;
    end
  end
endmodule

// *** tb/test_gpc_clock_control.sv ***
// Purpose: Self-checking bench for gpc_clock_control
// Assumes: AXI4-Lite master waits for every handshake; seed fixed
// Notes:   Toggle counts allow two of slack for synchroniser phase
`timescale 1ns/1ps
module test_gpc_clock_control;
  // Clock, reset and pins
  logic        mclk = 1'b0, rst_n = 1'b0, enPin = 1'b0, refRun = 1'b0;
  logic [7:0]  refHalf = 8'h10;
  wire logic   refClk;
  // AXI master side
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  wstrb = 4'hF;
  logic        awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  // Generated clocks and observers
  logic        outA, outB, outC, outX, lock;
  logic [2:0]  prevCore = 3'b000;
  logic [15:0] togA = 16'h0000, togB = 16'h0000, togC = 16'h0000;
  wire logic [15:0] refEdges, togX;
  // Bookkeeping; settings mirror what is written
  int          nErrors = 0, cmpCount = 0, sA, sB, sC, sX, s;
  int          m = 3, n = 2;
  int          divs[4] = '{4, 3, 6, 12};
  logic [31:0] rd, dly, hi;
  logic [1:0]  rs;

  always #12.5 mclk = ~mclk;

  gpc_clock_control i_dut (
    .mclk(mclk), .rst_n(rst_n), .refClkPin(refClk), .synthGlobalEnablePin(enPin),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(brdy),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rrdy),
    .coreOutA(outA), .coreOutB(outB), .coreOutC(outC), .boardOut(outX), .lockPin(lock)
  );

  gpc_board_partner i_board (
    .mclk(mclk), .refRun(refRun), .refHalf(refHalf), .refClkPin(refClk),
    .boardOut(outX), .refEdges(refEdges), .boardToggles(togX)
  );

  // Core clock toggle counters
  always @(posedge mclk) begin
    prevCore <= {outC, outB, outA};
    togA <= togA + 16'(outA !== prevCore[0]);
    togB <= togB + 16'(outB !== prevCore[1]);
    togC <= togC + 16'(outC !== prevCore[2]);
  end

  // Single comparison point
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      nErrors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("Comparisons %0d mismatches %0d", cmpCount, nErrors);
    if (nErrors == 0 && cmpCount > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Write: address and data offered together, each dropped when taken
  task automatic axiWr(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] rsp);
    int t;
    t = 0;
    @(posedge mclk);
    awaddr <= ad;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    do begin
      @(posedge mclk);
      t++;
      if (awv && awready === 1'b1) awv <= 1'b0;
      if (wv && wready === 1'b1) wv <= 1'b0;
    end while (bvalid !== 1'b1 && t < 200);
    rsp = bresp;
    brdy <= 1'b0;
  endtask

  task automatic axiRd(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] rsp);
    int t;
    t = 0;
    @(posedge mclk);
    araddr <= ad;
    arv <= 1'b1;
    rrdy <= 1'b1;
    do begin
      @(posedge mclk);
      t++;
      if (arv && arready === 1'b1) arv <= 1'b0;
    end while (rvalid !== 1'b1 && t < 200);
    d = rdata;
    rsp = rresp;
    rrdy <= 1'b0;
  endtask

  task automatic rdChk(input string nm, input logic [7:0] ad, input logic [31:0] e);
    axiRd(ad, rd, rs);
    check(nm, rd, e);
    check({nm, "Resp"}, 32'(rs), 32'h0);
  endtask

  task automatic wrChk(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] e);
    axiWr(ad, d, rs);
    check("bresp", 32'(rs), 32'(e));
  endtask

  // Bounded waits on the lock pin and on reference edges
  task automatic waitLock(input logic lv, input int lim);
    int t;
    t = 0;
    while (lock !== lv && t < lim) begin
      @(posedge mclk);
      t++;
    end
  endtask

  task automatic waitEdges(input int e);
    int t, st;
    t = 0;
    st = refEdges;
    while (int'(refEdges) - st < e && t < e * 20) begin
      @(posedge mclk);
      t++;
    end
  endtask

  task automatic snap;
    sA = togA;
    sB = togB;
    sC = togC;
    sX = togX;
  endtask

  // Expected toggles: edges times m over n times divider
  function automatic int expTog(input int e, input int div);
    return e * m / (n * div);
  endfunction

  task automatic rateChk(input string nm, input int got, input int e, input int div);
    int d;
    d = got - expTog(e, div);
    check(nm, 32'(d <= 2 && d >= -2), 32'h1);
  endtask

  // Shift is illegal in aligned modes or with a non-integer ratio
  function automatic logic cfgErr(input logic [31:0] w);
    logic bad;
    bad = 1'b0;
    foreach (divs[i]) bad |= ((n * divs[i]) % m != 0) && (m % (n * divs[i]) != 0);
    return ((w[5:4] != 2'b00) && (w[2:1] != 2'b00 || bad)) ||
           ((w[2:1] != 2'b00) && (dly[15:0] != 16'h8888));
  endfunction

  // Hang guard
  initial begin
    repeat (60000) @(posedge mclk);
    nErrors++;
    finish_test;
  end

  initial begin
    logic [31:0] modes[6];
    logic [7:0]  ads[6];
    int          vals[6];
    modes = '{32'h11, 32'h03, 32'h13, 32'h27, 32'h31, 32'h01};
    ads = '{gpc_pkg::OFF_MULT, gpc_pkg::OFF_PRE, gpc_pkg::OFF_DIVA,
            gpc_pkg::OFF_DIVB, gpc_pkg::OFF_DIVC, gpc_pkg::OFF_DIVX};
    vals = '{3, 2, 4, 3, 6, 12};
    void'($urandom(34));
    refHalf = 8'($urandom_range(35, 5));
    dly = 32'($urandom_range(16'hFFFF, 0));
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    // Reset values, outputs quiet, refusals
    for (int i = 0; i < 9; i++) rdChk("rstVal", 8'(4 * i), (i == 7) ? 32'h8888 : 32'(i < 7));
    check("outsRst", 32'({outA, outB, outC, outX, lock}), 32'h0);
    axiRd(8'h40, rd, rs);
    check("unmapData", rd, 32'h0);
    check("unmapResp", 32'(rs), 32'h2);
    wrChk(gpc_pkg::OFF_STATUS, 32'h1, 2'b10);
    // Range limits, then working ratios
    wrChk(gpc_pkg::OFF_MULT, 32'(gpc_pkg::CORE_MAX), 2'b00);
    rdChk("multMax", gpc_pkg::OFF_MULT, 32'h0000_00A0);
    wrChk(gpc_pkg::OFF_PRE, 32'(gpc_pkg::SMALL_MAX), 2'b00);
    rdChk("preMax", gpc_pkg::OFF_PRE, 32'h0000_0010);
    wrChk(gpc_pkg::OFF_MULT, 32'h0000_00A1, 2'b00);
    axiRd(gpc_pkg::OFF_STATUS, rd, rs);
    check("rangeErr", 32'(rd[3]), 32'h1);
    for (int i = 0; i < 6; i++) begin
      wrChk(ads[i], 32'(vals[i]), 2'b00);
      rdChk("setting", ads[i], 32'(vals[i]));
    end
    wrChk(gpc_pkg::OFF_DELAY, dly, 2'b00);
    rdChk("delay", gpc_pkg::OFF_DELAY, dly);
    // Byte strobe: only lane 1 written, lane 0 kept
    wstrb <= 4'h2;
    wrChk(gpc_pkg::OFF_DELAY, 32'h0, 2'b00);
    wstrb <= 4'hF;
    dly &= 32'h0000_00FF;
    rdChk("strobe", gpc_pkg::OFF_DELAY, dly);
    // Every mode with a phase shift; normal and zero-delay also without
    for (int i = 0; i < 6; i++) begin
      wrChk(gpc_pkg::OFF_CTRL, modes[i], 2'b00);
      axiRd(gpc_pkg::OFF_STATUS, rd, rs);
      check("cfgErr", 32'(rd[3]), 32'(cfgErr(modes[i])));
    end
    // Acquire lock, settings then frozen
    s = refEdges;
    refRun <= 1'b1;
    enPin <= 1'b1;
    waitLock(1'b1, 3000);
    check("lock", 32'(lock), 32'h1);
    check("acqLen", 32'(int'(refEdges) - s >= gpc_pkg::LOCK_CYCLES), 32'h1);
    wrChk(gpc_pkg::OFF_MULT, 32'h5, 2'b10);
    rdChk("multKept", gpc_pkg::OFF_MULT, 32'h3);
    rdChk("status", gpc_pkg::OFF_STATUS, 32'h3);
    snap();
    waitEdges(240);
    rateChk("rateA", togA - sA, 240, 4);
    rateChk("rateB", togB - sB, 240, 3);
    rateChk("rateC", togC - sC, 240, 6);
    rateChk("rateX", togX - sX, 240, 12);
    // Reference stops, then returns
    refRun <= 1'b0;
    waitLock(1'b0, 40);
    check("lockLost", 32'(lock), 32'h0);
    refRun <= 1'b1;
    waitLock(1'b1, 3000);
    check("relockRef", 32'(lock), 32'h1);
    // Global enable low holds everything low
    enPin <= 1'b0;
    repeat (6) @(posedge mclk);
    hi = 32'h0;
    repeat (50) begin
      @(posedge mclk);
      hi |= 32'({outA, outB, outC, outX, lock});
    end
    check("offLow", hi, 32'h0);
    wrChk(gpc_pkg::OFF_CTRL, 32'h9, 2'b00);
    enPin <= 1'b1;
    waitEdges(32);
    check("relockLow", 32'(lock), 32'h0);
    waitLock(1'b1, 3000);
    check("relock", 32'(lock), 32'h1);
    snap();
    waitEdges(240);
    rateChk("mirror", togX - sX, 240, 3);
    // Instance that ignores the global enable
    enPin <= 1'b0;
    waitLock(1'b0, 20);
    wrChk(gpc_pkg::OFF_CTRL, 32'h0, 2'b00);
    waitLock(1'b1, 3000);
    check("noGlobal", 32'(lock), 32'h1);
    snap();
    waitEdges(80);
    rateChk("rateFree", togB - sB, 80, 3);
    finish_test;
  end
endmodule
